/* File: verilog/timer2_block.sv */
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "timer2_regs.svh"
module timer2_block #(
    parameter int MC_DIV = `MC_DIV
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins
    input  wire logic        trigger_pin,
    input  wire logic        external_count_pin,
    input  wire logic        tmr_a_count_pin,
    input  wire logic        tmr_b_count_pin,
    input  wire logic        ext_irq_a_pin,
    input  wire logic        ext_irq_b_pin,
    // serial port bit clocks
    output logic             port1_rx_baud_tick,
    output logic             port1_tx_baud_tick,
    output logic             port2_rx_baud_tick,
    output logic             port2_tx_baud_tick,
    // flag levels towards the interrupt controller
    output logic             t2_irq_req,
    output logic             tmr_a_irq_req,
    output logic             tmr_b_irq_req
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: 3 flops, level changes once stages 2 and 3 agree

    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] sync3_r;
    logic [NPIN-1:0] lvl_r;
    logic [NPIN-1:0] fall_r;

    assign pin_in = {ext_irq_b_pin, ext_irq_a_pin, tmr_b_count_pin,
                     tmr_a_count_pin, external_count_pin, trigger_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                    sync3_r[gi] <= 1'b1;
                    lvl_r[gi]   <= 1'b1;
                    fall_r[gi]  <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi])
                        lvl_r[gi] <= sync3_r[gi];
                    fall_r[gi] <= lvl_r[gi] & (sync2_r[gi] == sync3_r[gi]) & ~sync3_r[gi];
                end
            end
        end
    endgenerate

    logic trig_lvl;
    logic trig_fall;
    logic t2_pin_fall;
    logic a_pin_fall;
    logic b_pin_fall;
    logic irq_a_lvl;
    logic irq_b_lvl;
    assign trig_lvl    = lvl_r[0];
    assign trig_fall   = fall_r[0];
    assign t2_pin_fall = fall_r[1];
    assign a_pin_fall  = fall_r[2];
    assign b_pin_fall  = fall_r[3];
    assign irq_a_lvl   = lvl_r[4];
    assign irq_b_lvl   = lvl_r[5];

////////////////////////////////////////////////////////////////////////////////
// machine cycle prescaler

    logic [7:0] mc_cnt_r;
    logic       mc_tick;
    assign mc_tick = (mc_cnt_r == 8'(MC_DIV - 1));

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            mc_cnt_r <= 8'h00;
        else if (mc_tick)
            mc_cnt_r <= 8'h00;
        else
            mc_cnt_r <= mc_cnt_r + 8'h01;
    end

////////////////////////////////////////////////////////////////////////////////
// registers and bus decode

    logic [7:0]  ctrl_r;
    logic [7:0]  t2mode_r;
    logic [7:0]  power_control_register_r;
    logic [7:0]  bmode_r;
    logic [1:0]  brun_r;
    logic        a_flag_r;
    logic        b_flag_r;
    logic [15:0] t2_cnt_r;
    logic [15:0] caprel_r;
    logic [15:0] a_cnt_r;
    logic [15:0] b_cnt_r;
    logic        ack_r;
    logic        wr;
    logic [7:0]  wd;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
    assign wd = wb_dat_i[7:0];

    logic baud_any;
    logic trig_ev;
    logic updown;
    timer2_pkg::t2_mode_e t2_mode;

    assign baud_any = ctrl_r[`BIT_P1_RX_SEL] | ctrl_r[`BIT_P1_TX_SEL]
                    | power_control_register_r[`BIT_P2_RX_SEL] | power_control_register_r[`BIT_P2_TX_SEL];
    assign trig_ev  = trig_fall & ctrl_r[`BIT_TRIG_EN];

    always_comb
    begin
        if (!ctrl_r[`BIT_T2_RUN])
            t2_mode = timer2_pkg::T2_OFF;
        else if (baud_any)
            t2_mode = timer2_pkg::T2_BAUD;
        else if (ctrl_r[`BIT_CAP_SEL])
            t2_mode = timer2_pkg::T2_CAPTURE;
        else
            t2_mode = timer2_pkg::T2_RELOAD;
    end

    assign updown = (t2_mode == timer2_pkg::T2_RELOAD) & t2mode_r[`BIT_UPDOWN_EN];

////////////////////////////////////////////////////////////////////////////////
// timer 2 counting

    logic        t2_tick;
    logic        t2_ovf;
    logic [15:0] t2_nxt;

    assign t2_tick = ctrl_r[`BIT_T2_RUN]
                   & (ctrl_r[`BIT_T2_SRC] ? t2_pin_fall : mc_tick);

    always_comb
    begin
        t2_ovf = 1'b0;
        t2_nxt = t2_cnt_r;
        if (t2_tick)
        begin
            if (updown && !trig_lvl)
            begin
                if (t2_cnt_r == caprel_r)
                begin
                    t2_ovf = 1'b1;
                    t2_nxt = 16'hFFFF;
                end
                else
                    t2_nxt = t2_cnt_r - 16'h0001;
            end
            else if (t2_cnt_r == 16'hFFFF)
            begin
                t2_ovf = 1'b1;
                // capture mode just wraps; others reload
                t2_nxt = (t2_mode == timer2_pkg::T2_CAPTURE) ? 16'h0000 : caprel_r;
            end
            else
                t2_nxt = t2_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            t2_cnt_r <= 16'h0000;
            caprel_r <= 16'h0000;
        end
        else
        begin
            t2_cnt_r <= t2_nxt;
            if (trig_ev && t2_mode == timer2_pkg::T2_RELOAD && !updown)
                t2_cnt_r <= caprel_r;
            if (trig_ev && t2_mode == timer2_pkg::T2_CAPTURE)
                caprel_r <= t2_cnt_r;
            // software access wins over counting in the same cycle
            if (wr && wb_adr_i == `ADR_T2_COUNT_LOW)
                t2_cnt_r[7:0] <= wd;
            if (wr && wb_adr_i == `ADR_T2_COUNT_HIGH)
                t2_cnt_r[15:8] <= wd;
            if (wr && wb_adr_i == `ADR_CAPREL_LOW)
                caprel_r[7:0] <= wd;
            if (wr && wb_adr_i == `ADR_CAPREL_HIGH)
                caprel_r[15:8] <= wd;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// timer 2 control and flags: hardware set beats software clear

    logic ovf_set;
    logic ext_set;
    assign ovf_set = t2_ovf & ~baud_any;
    // up/down mode uses the pin as direction, so no event there
    assign ext_set = trig_ev & ~updown & (t2_mode != timer2_pkg::T2_OFF);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_r <= `RST_BYTE;
        else
        begin
            if (wr && wb_adr_i == `ADR_T2_CONTROL)
                ctrl_r <= wd;
            if (ovf_set)
                ctrl_r[`BIT_T2_OVF] <= 1'b1;
            if (ext_set)
                ctrl_r[`BIT_T2_EXT] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            t2mode_r <= `RST_BYTE;
            power_control_register_r   <= `RST_BYTE;
            bmode_r  <= `RST_BYTE;
        end
        else
        begin
            if (wr && wb_adr_i == `ADR_T2_MODE)
                t2mode_r <= {7'h00, wd[`BIT_UPDOWN_EN]};
            if (wr && wb_adr_i == `ADR_POWER_CONTROL)
                power_control_register_r <= {6'h00, wd[1:0]};
            if (wr && wb_adr_i == `ADR_BASIC_MODE)
                bmode_r <= wd;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// basic timers a and b

    function automatic logic [16:0] basic_step(input logic [15:0] v, input logic [1:0] m);
        logic [13:0] c13;
        logic [8:0]  c8;
        logic [16:0] r;
        begin
            c13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
            c8  = {1'b0, v[7:0]} + 9'h001;
            case (m)
                `MODE_13BIT:   r = {c13[13], c13[12:5], v[7:5], c13[4:0]};
                `MODE_16BIT:   r = {1'b0, v} + 17'h00001;
                `MODE_RELOAD8: r = c8[8] ? {1'b1, v[15:8], v[15:8]} : {1'b0, v[15:8], c8[7:0]};
                // fourth mode: low byte alone, high byte handled apart
                default:       r = {c8[8], v[15:8], c8[7:0]};
            endcase
            basic_step = r;
        end
    endfunction

    logic [1:0]  a_mode;
    logic [1:0]  b_mode;
    logic        a_split;
    logic        a_tick;
    logic        ah_tick;
    logic        b_tick;
    logic [16:0] a_res;
    logic [16:0] b_res;
    logic [8:0]  ah_res;
    logic        a_ovf;
    logic        ah_ovf;
    logic        b_ovf;

    assign a_mode  = bmode_r[1:0];
    assign b_mode  = bmode_r[`BASIC_B_SHIFT+1:`BASIC_B_SHIFT];
    assign a_split = (a_mode == `MODE_FOURTH);

    assign a_tick  = brun_r[`BIT_A_RUN]
                   & (~bmode_r[`BIT_BASIC_GATE] | irq_a_lvl)
                   & (bmode_r[`BIT_BASIC_SRC] ? a_pin_fall : mc_tick);
    assign ah_tick = a_split & brun_r[`BIT_B_RUN] & mc_tick;
    assign b_tick  = brun_r[`BIT_B_RUN] & (b_mode != `MODE_FOURTH)
                   & (~bmode_r[`BASIC_B_SHIFT+`BIT_BASIC_GATE] | irq_b_lvl)
                   & (bmode_r[`BASIC_B_SHIFT+`BIT_BASIC_SRC] ? b_pin_fall : mc_tick);

    assign a_res  = basic_step(a_cnt_r, a_mode);
    assign b_res  = basic_step(b_cnt_r, b_mode);
    assign ah_res = {1'b0, a_cnt_r[15:8]} + 9'h001;
    assign a_ovf  = a_tick & a_res[16];
    assign ah_ovf = ah_tick & ah_res[8];
    assign b_ovf  = b_tick & b_res[16];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            a_cnt_r <= 16'h0000;
            b_cnt_r <= 16'h0000;
        end
        else
        begin
            if (a_tick)
                a_cnt_r[7:0] <= a_res[7:0];
            if (a_split ? ah_tick : a_tick)
                a_cnt_r[15:8] <= a_split ? ah_res[7:0] : a_res[15:8];
            if (b_tick)
                b_cnt_r <= b_res[15:0];
            if (wr && wb_adr_i == `ADR_TMR_A_LOW)
                a_cnt_r[7:0] <= wd;
            if (wr && wb_adr_i == `ADR_TMR_A_HIGH)
                a_cnt_r[15:8] <= wd;
            if (wr && wb_adr_i == `ADR_TMR_B_LOW)
                b_cnt_r[7:0] <= wd;
            if (wr && wb_adr_i == `ADR_TMR_B_HIGH)
                b_cnt_r[15:8] <= wd;
        end
    end

    logic b_flag_set;
    // split high byte takes over timer b's flag; b keeps only baud duty
    assign b_flag_set = a_split ? ah_ovf : b_ovf;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            brun_r   <= 2'b00;
            a_flag_r <= 1'b0;
            b_flag_r <= 1'b0;
        end
        else
        begin
            if (wr && wb_adr_i == `ADR_BASIC_CONTROL)
            begin
                brun_r   <= {wd[`BIT_B_RUN], wd[`BIT_A_RUN]};
                a_flag_r <= wd[`BIT_A_OVF];
                b_flag_r <= wd[`BIT_B_OVF];
            end
            if (a_ovf)
                a_flag_r <= 1'b1;
            if (b_flag_set)
                b_flag_r <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// outputs: baud ticks and flag levels

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            port1_rx_baud_tick <= 1'b0;
            port1_tx_baud_tick <= 1'b0;
            port2_rx_baud_tick <= 1'b0;
            port2_tx_baud_tick <= 1'b0;
            t2_irq_req         <= 1'b0;
            tmr_a_irq_req      <= 1'b0;
            tmr_b_irq_req      <= 1'b0;
        end
        else
        begin
            port1_rx_baud_tick <= ctrl_r[`BIT_P1_RX_SEL] ? t2_ovf : b_ovf;
            port1_tx_baud_tick <= ctrl_r[`BIT_P1_TX_SEL] ? t2_ovf : b_ovf;
            port2_rx_baud_tick <= power_control_register_r[`BIT_P2_RX_SEL] ? t2_ovf : b_ovf;
            port2_tx_baud_tick <= power_control_register_r[`BIT_P2_TX_SEL] ? t2_ovf : b_ovf;
            t2_irq_req         <= ctrl_r[`BIT_T2_OVF] | ctrl_r[`BIT_T2_EXT];
            tmr_a_irq_req      <= a_flag_r;
            tmr_b_irq_req      <= b_flag_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// wishbone answer: ack one cycle after the request, unmapped reads zero

    logic [7:0] rd;

    always_comb
    begin
        case (wb_adr_i)
            `ADR_T2_CONTROL:    rd = ctrl_r;
            `ADR_T2_MODE:       rd = {t2_mode, 3'b000, t2mode_r[`BIT_UPDOWN_EN]};
            `ADR_T2_COUNT_LOW:  rd = t2_cnt_r[7:0];
            `ADR_T2_COUNT_HIGH: rd = t2_cnt_r[15:8];
            `ADR_CAPREL_LOW:    rd = caprel_r[7:0];
            `ADR_CAPREL_HIGH:   rd = caprel_r[15:8];
            `ADR_POWER_CONTROL: rd = power_control_register_r;
            `ADR_BASIC_MODE:    rd = bmode_r;
            `ADR_BASIC_CONTROL: rd = {4'h0, b_flag_r, a_flag_r, brun_r};
            `ADR_TMR_A_LOW:     rd = a_cnt_r[7:0];
            `ADR_TMR_A_HIGH:    rd = a_cnt_r[15:8];
            `ADR_TMR_B_LOW:     rd = b_cnt_r[7:0];
            `ADR_TMR_B_HIGH:    rd = b_cnt_r[15:8];
            default:            rd = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ack_r    <= wb_cyc_i & wb_stb_i & ~ack_r;
            wb_dat_o <= {24'h000000, rd};
        end
    end

    assign wb_ack_o = ack_r;

endmodule

/* File: verilog/timer2_regs.svh */
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// register byte addresses
`define ADR_T2_CONTROL      8'h00
`define ADR_T2_MODE         8'h04
`define ADR_T2_COUNT_LOW    8'h08
`define ADR_T2_COUNT_HIGH   8'h0C
`define ADR_CAPREL_LOW      8'h10
`define ADR_CAPREL_HIGH     8'h14
`define ADR_POWER_CONTROL   8'h18
`define ADR_BASIC_MODE      8'h1C
`define ADR_BASIC_CONTROL   8'h20
`define ADR_TMR_A_LOW       8'h24
`define ADR_TMR_A_HIGH      8'h28
`define ADR_TMR_B_LOW       8'h2C
`define ADR_TMR_B_HIGH      8'h30

// timer2_control bits
`define BIT_T2_OVF          7
`define BIT_T2_EXT          6
`define BIT_P1_RX_SEL       5
`define BIT_P1_TX_SEL       4
`define BIT_TRIG_EN         3
`define BIT_T2_RUN          2
`define BIT_T2_SRC          1
`define BIT_CAP_SEL         0
// t2_mode_register and power_control_register bits
`define BIT_UPDOWN_EN       0
`define BIT_P2_RX_SEL       1
`define BIT_P2_TX_SEL       0
// basic timer mode register: timer a in [3:0], timer b in [7:4]
`define BASIC_B_SHIFT       4
`define BIT_BASIC_SRC       2
`define BIT_BASIC_GATE      3
// basic control register bits
`define BIT_A_RUN           0
`define BIT_B_RUN           1
`define BIT_A_OVF           2
`define BIT_B_OVF           3

// basic timer modes
`define MODE_13BIT          2'b00
`define MODE_16BIT          2'b01
`define MODE_RELOAD8        2'b10
`define MODE_FOURTH         2'b11

`define RST_BYTE            8'h00
`define MC_DIV              12

`endif

/* File: verilog/timer2_pkg.sv */
package timer2_pkg;
    typedef enum logic [3:0] {
        T2_OFF     = 4'b0001,
        T2_CAPTURE = 4'b0010,
        T2_RELOAD  = 4'b0100,
        T2_BAUD    = 4'b1000
    } t2_mode_e;
endpackage

/* File: test/timer2_block_monitor.sv */
`timescale 1ns/1ps
`include "timer2_regs.svh"
module timer2_block_monitor #(
    parameter int MC_DIV = 2
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // outputs
    input wire logic        port1_rx_baud_tick,
    input wire logic        port2_tx_baud_tick,
    input wire logic        t2_irq_req,
    input wire logic        tmr_a_irq_req,
    input wire logic        tmr_b_irq_req
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // flags drop only through a completed software write
    logic ctl_wr;
    logic bas_wr;
    assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADR_T2_CONTROL;
    assign bas_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADR_BASIC_CONTROL;
    ////////////////////////////////////////////////////////////
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered one cycle later");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_P1_RX_TICK: assert property (port1_rx_baud_tick |=> !port1_rx_baud_tick)
        else $error("port one receive tick wider than one cycle");
    AST_P2_TX_TICK: assert property (port2_tx_baud_tick |=> !port2_tx_baud_tick)
        else $error("port two transmit tick wider than one cycle");
    AST_T2_CLR: assert property ($fell(t2_irq_req) |-> $past(ctl_wr))
        else $error("timer2 flag cleared without a write");
    AST_A_CLR: assert property ($fell(tmr_a_irq_req) |-> $past(bas_wr))
        else $error("timer a flag cleared without a write");
    AST_B_CLR: assert property ($fell(tmr_b_irq_req) |-> $past(bas_wr))
        else $error("timer b flag cleared without a write");
endmodule

bind timer2_block timer2_block_monitor #(.MC_DIV(MC_DIV)) i_timer2_block_monitor (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port1_rx_baud_tick(port1_rx_baud_tick),
    .port2_tx_baud_tick(port2_tx_baud_tick), .t2_irq_req(t2_irq_req),
    .tmr_a_irq_req(tmr_a_irq_req), .tmr_b_irq_req(tmr_b_irq_req)
);

/* File: test/pin_far_side.sv */
`timescale 1ns/1ps
module pin_far_side (
    // clock
    input wire logic ref_clk,
    // pins towards the block
    output logic     trigger_pin,
    output logic     external_count_pin,
    output logic     tmr_a_count_pin,
    output logic     tmr_b_count_pin,
    output logic     ext_irq_a_pin,
    output logic     ext_irq_b_pin,
    // bit clocks from the block
    input wire logic port1_rx_baud_tick,
    input wire logic port1_tx_baud_tick,
    input wire logic port2_rx_baud_tick,
    input wire logic port2_tx_baud_tick
);
    int ticks [4] = '{default: 0};
    initial
    begin
        trigger_pin = 1'b1;
        external_count_pin = 1'b1;
        tmr_a_count_pin = 1'b1;
        tmr_b_count_pin = 1'b1;
        ext_irq_a_pin = 1'b1;
        ext_irq_b_pin = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
    begin
        ticks[0] <= ticks[0] + int'(port1_rx_baud_tick === 1'b1);
        ticks[1] <= ticks[1] + int'(port1_tx_baud_tick === 1'b1);
        ticks[2] <= ticks[2] + int'(port2_rx_baud_tick === 1'b1);
        ticks[3] <= ticks[3] + int'(port2_tx_baud_tick === 1'b1);
    end
    // levels held 8 cycles: far slower than half the count rate
    task automatic pulse(input logic ext, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            if (ext)
                external_count_pin <= 1'b0;
            else
                trigger_pin <= 1'b0;
            repeat (8) @(posedge ref_clk);
            external_count_pin <= 1'b1;
            trigger_pin <= 1'b1;
            repeat (8) @(posedge ref_clk);
        end
    endtask
    task automatic level(input logic v);
        @(posedge ref_clk);
        trigger_pin <= v;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

/* File: test/timer2_block_tb_top.sv */
`timescale 1ns/1ps
`include "timer2_regs.svh"
module timer2_block_tb_top;
    logic        ref_clk;
    logic        sys_rst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        trg, xc, ac, bc, ia, ib;
    logic [3:0]  tk;
    logic        t2_irq_req, tmr_a_irq_req, tmr_b_irq_req;
    int          mismatches, checks_done, cycles;
    int          t0 [4];
    timer2_block #(.MC_DIV(2)) i_timer2_block (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger_pin(trg),
        .external_count_pin(xc), .tmr_a_count_pin(ac), .tmr_b_count_pin(bc),
        .ext_irq_a_pin(ia), .ext_irq_b_pin(ib), .port1_rx_baud_tick(tk[0]),
        .port1_tx_baud_tick(tk[1]), .port2_rx_baud_tick(tk[2]), .port2_tx_baud_tick(tk[3]),
        .t2_irq_req(t2_irq_req), .tmr_a_irq_req(tmr_a_irq_req), .tmr_b_irq_req(tmr_b_irq_req));
    pin_far_side i_pin_far_side (
        .ref_clk(ref_clk), .trigger_pin(trg), .external_count_pin(xc), .tmr_a_count_pin(ac),
        .tmr_b_count_pin(bc), .ext_irq_a_pin(ia), .ext_irq_b_pin(ib),
        .port1_rx_baud_tick(tk[0]), .port1_tx_baud_tick(tk[1]),
        .port2_rx_baud_tick(tk[2]), .port2_tx_baud_tick(tk[3]));
    ////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs about a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, wd};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 100);
        if (wb_ack_o !== 1'b1)
            mismatches++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] v;
        xfer(1'b1, adr, d, v);
    endtask
    task automatic rc(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] v;
        xfer(1'b0, adr, 8'h00, v);
        check(v, {24'h000000, exp});
    endtask
    // byte pairs: high byte sits one word above the low byte
    task automatic set16(input logic [7:0] adr, input logic [15:0] v);
        wr(adr, v[7:0]);
        wr(adr + 8'h04, v[15:8]);
    endtask
    function automatic int gain(input int i);
        return i_pin_far_side.ticks[i] - t0[i];
    endfunction
    task automatic trig_case(input logic [15:0] cnt, input logic [15:0] rel,
                             input logic [7:0] ctl, input logic [7:0] ectl,
                             input logic [7:0] adr, input logic [7:0] ehi);
        set16(`ADR_T2_COUNT_LOW, cnt);
        set16(`ADR_CAPREL_LOW, rel);
        wr(`ADR_T2_CONTROL, ctl);
        i_pin_far_side.pulse(1'b0, 1);
        rc(`ADR_T2_CONTROL, ectl);
        wr(`ADR_T2_CONTROL, 8'h00);
        rc(adr, ehi);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h00000000;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rc(`ADR_T2_MODE, 8'h10);
        wr(8'h40, 8'hFF);
        rc(8'h40, 8'h00);
        $display("test reset done");
        trig_case(16'h0000, 16'h5600, 8'h0C, 8'h4C, `ADR_T2_COUNT_HIGH, 8'h56);
        trig_case(16'h0000, 16'h5600, 8'h04, 8'h04, `ADR_T2_COUNT_HIGH, 8'h00);
        trig_case(16'h7700, 16'h0000, 8'h0D, 8'h4D, `ADR_CAPREL_HIGH, 8'h77);
        $display("test trigger done");
        set16(`ADR_T2_COUNT_LOW, 16'hFFF8);
        wr(`ADR_T2_CONTROL, 8'h05);
        repeat (30) @(posedge ref_clk);
        rc(`ADR_T2_CONTROL, 8'h85);
        check({31'h0, t2_irq_req}, 32'h1);
        wr(`ADR_T2_CONTROL, 8'h00);
        rc(`ADR_T2_COUNT_HIGH, 8'h00);
        set16(`ADR_T2_COUNT_LOW, 16'hFFFE);
        set16(`ADR_CAPREL_LOW, 16'h1200);
        wr(`ADR_T2_CONTROL, 8'h04);
        repeat (12) @(posedge ref_clk);
        rc(`ADR_T2_CONTROL, 8'h84);
        wr(`ADR_T2_CONTROL, 8'h00);
        rc(`ADR_T2_COUNT_HIGH, 8'h12);
        $display("test overflow done");
        wr(`ADR_T2_MODE, 8'h01);
        for (int d = 0; d < 2; d++)
        begin
            i_pin_far_side.level(d[0]);
            set16(`ADR_T2_COUNT_LOW, 16'h8000);
            wr(`ADR_T2_CONTROL, 8'h04);
            rc(`ADR_T2_MODE, 8'h41);
            wr(`ADR_T2_CONTROL, 8'h00);
            rc(`ADR_T2_COUNT_HIGH, d ? 8'h80 : 8'h7F);
        end
        wr(`ADR_T2_MODE, 8'h00);
        $display("test direction done");
        set16(`ADR_T2_COUNT_LOW, 16'hFFF0);
        set16(`ADR_CAPREL_LOW, 16'hFFF0);
        wr(`ADR_POWER_CONTROL, 8'h01);
        t0 = i_pin_far_side.ticks;
        wr(`ADR_T2_CONTROL, 8'h3D);
        repeat (300) @(posedge ref_clk);
        rc(`ADR_T2_MODE, 8'h80);
        i_pin_far_side.pulse(1'b0, 1);
        rc(`ADR_T2_CONTROL, 8'h7D);
        wr(`ADR_T2_CONTROL, 8'h00);
        wr(`ADR_POWER_CONTROL, 8'h00);
        check(gain(0) > 4, 32'h1);
        check(gain(1) > 4, 32'h1);
        check(gain(3) > 4, 32'h1);
        check(gain(2), 32'h0);
        $display("test baud done");
        set16(`ADR_T2_COUNT_LOW, 16'h0000);
        wr(`ADR_T2_CONTROL, 8'h06);
        i_pin_far_side.pulse(1'b1, 5);
        wr(`ADR_T2_CONTROL, 8'h00);
        rc(`ADR_T2_COUNT_LOW, 8'h05);
        i_pin_far_side.pulse(1'b1, 2);
        rc(`ADR_T2_COUNT_LOW, 8'h05);
        $display("test count done");
        wr(`ADR_BASIC_MODE, 8'h30);
        wr(`ADR_TMR_B_LOW, 8'h10);
        wr(`ADR_BASIC_CONTROL, 8'h02);
        repeat (40) @(posedge ref_clk);
        rc(`ADR_TMR_B_LOW, 8'h10);
        wr(`ADR_BASIC_CONTROL, 8'h00);
        wr(`ADR_BASIC_MODE, 8'h13);
        set16(`ADR_TMR_A_LOW, 16'hFEF0);
        set16(`ADR_TMR_B_LOW, 16'hFFF0);
        t0 = i_pin_far_side.ticks;
        wr(`ADR_BASIC_CONTROL, 8'h03);
        repeat (80) @(posedge ref_clk);
        rc(`ADR_BASIC_CONTROL, 8'h0F);
        check({30'h0, tmr_a_irq_req, tmr_b_irq_req}, 32'h3);
        check(gain(1) > 0, 32'h1);
        check(gain(0) > 0, 32'h1);
        check(gain(2) > 0, 32'h1);
        wr(`ADR_BASIC_CONTROL, 8'h00);
        $display("test basic done");
        print_verdict();
    end
endmodule
